// >>> hdl/wkr_pkg.sv
/*
  Shared constants for the watchdog and key-reset block: clock rates,
  prescaler taps, reset hold lengths, watchdog intervals, register map.
  Assumes a single 25 MHz system clock and a 32-bit APB register bus.
*/
package wkr_pkg;

  // ==========================================================================
  // clocking
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int PRESC_BASE_HZ = 32768;
  // tap-zero enable divisor, rounded down so the tap never runs slow
  localparam int PRESC_DIV = SYS_CLK_HZ / PRESC_BASE_HZ;
  localparam int PRESC_WIDTH = 16;
  localparam int TAP_TEN = 10;

  // ==========================================================================
  // reset hold lengths in prescaler clocks
  localparam int RESET_HOLD_LONG = 16384;
  localparam int RESET_HOLD_SHORT = 2048;
  localparam int HOLD_CNT_WIDTH = 15;

  // ==========================================================================
  // watchdog
  localparam int WDT_WIDTH = 9;
  localparam int WDT_INTERVAL_8 = 8;
  localparam int WDT_INTERVAL_64 = 64;
  localparam int WDT_INTERVAL_512 = 512;
  localparam int KEY_PINS = 4;

  // ==========================================================================
  // register map, byte addresses
  localparam int ADDR_WIDTH = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CMD = 8'h10;

  // field positions
  localparam int CTRL_SCAN_SRC_BIT = 0;
  localparam int CMD_WDT_SET_BIT = 0;
  localparam int EV_WDT_BIT = 0;
  localparam int EV_KEY_BIT = 1;
  localparam int EV_WIDTH = 2;
  localparam int ST_FLAG_BIT = 0;
  localparam int ST_EN_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_KEYLOW_BIT = 3;
  localparam int ST_COUNT_LSB = 16;

  // terminal count of the watchdog for an interval in tenth-tap periods
  function automatic logic [WDT_WIDTH-1:0] wkr_terminal(input int interval);
    logic [31:0] t;
    t = interval - 1;
    return t[WDT_WIDTH-1:0];
  endfunction : wkr_terminal

endpackage : wkr_pkg

// >>> hdl/wkr_reset_hold.sv
/*
  Internal reset cycle generator: holds the chip reset for a fixed number
  of prescaler clocks after power-up or after any reset request pulse.
  Assumes tick is a one-cycle enable at the prescaler tap-zero rate.
*/
`timescale 1ns/100ps
module wkr_reset_hold
  import wkr_pkg::*;
#(
  parameter int HOLD_CLOCKS = RESET_HOLD_LONG
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // prescaler rate and request
  input wire logic tick,
  input wire logic request,
  // internal reset, active low
  output logic hold_n
);

  localparam logic [HOLD_CNT_WIDTH-1:0] LAST = HOLD_CNT_WIDTH'(HOLD_CLOCKS - 1);

  logic [HOLD_CNT_WIDTH-1:0] count;

  // ==========================================================================
  // hold counter; a new request restarts the full length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_n <= 1'b0;
      count <= '0;
    end else if (request) begin
      hold_n <= 1'b0;
      count <= '0;
    end else if (!hold_n && tick) begin
      if (count == LAST) begin
        hold_n <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // release only after the full count of prescaler clocks
  hold_min_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(hold_n) |-> $past(count) == LAST && $past(tick))
    else $error("reset hold released early");

endmodule : wkr_reset_hold

// >>> hdl/wkr_top.sv
/*
  Watchdog and key-reset block: prescaler chain, nine-bit watchdog,
  key all-low detector, reset cycle generator, APB registers, interrupt.
  Assumes all inputs synchronous to SYS_CLK; the CPU decodes its own
  watchdog set instruction and reports halt and stop as levels.
*/
`timescale 1ns/100ps
module wkr_top
  import wkr_pkg::*;
#(
  parameter logic [KEY_PINS-1:0] KEY_RESET_USE = 4'hf,
  parameter int WDT_INTERVAL = WDT_INTERVAL_512,
  parameter int RESET_HOLD_CLOCKS = RESET_HOLD_LONG,
  parameter int PRESC_CYCLES = PRESC_DIV
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_WIDTH-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // cpu side
  input wire logic WDT_SET,
  input wire logic HALT_MODE,
  input wire logic STOP_MODE,
  // key pins
  input wire logic [KEY_PINS-1:0] PORT_C_PINS,
  input wire logic [KEY_PINS-1:0] KEY_SCAN_INPUTS,
  input wire logic [KEY_PINS-1:0] PIN_IS_INPUT,
  input wire logic KEY_SCAN_DONE,
  // results
  output logic CHIP_RESET_N,
  output logic WATCHDOG_FLAG,
  output logic IRQ
);

  localparam logic [WDT_WIDTH-1:0] TERM = wkr_terminal(WDT_INTERVAL);
  localparam int DIV_WIDTH = $clog2(PRESC_CYCLES + 1);
  localparam logic [DIV_WIDTH-1:0] DIV_LAST = DIV_WIDTH'(PRESC_CYCLES - 1);
  localparam logic [TAP_TEN-1:0] TAP_TEN_ALL = '1;

  // prescaler
  logic [DIV_WIDTH-1:0] div_count;
  logic tap_zero_tick;
  logic [PRESC_WIDTH-1:0] presc_chain;
  logic tap_ten_tick;

  // watchdog
  logic wdt_enable;
  logic [WDT_WIDTH-1:0] wdt_count;
  logic wdt_overflow;
  logic wdt_set;
  logic paused;

  // key detector
  logic [KEY_PINS-1:0] key_mask;
  logic [KEY_PINS-1:0] key_pins;
  logic all_low;
  logic qualified;
  logic key_low_q;
  logic key_req;

  // registers
  logic scan_src;
  logic [EV_WIDTH-1:0] events;
  logic [EV_WIDTH-1:0] mask;
  logic [EV_WIDTH-1:0] next_events;
  logic wr_en;
  logic rd_en;
  logic cmd_set;
  logic mapped;
  logic [31:0] next_rdata;

  // ==========================================================================
  // prescaler
  // tap-zero enable from the system clock divider
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_count <= '0;
      tap_zero_tick <= 1'b0;
    end else if (div_count == DIV_LAST) begin
      div_count <= '0;
      tap_zero_tick <= 1'b1;
    end else begin
      div_count <= div_count + 1'b1;
      tap_zero_tick <= 1'b0;
    end
  end

  // the chain only sees RSTN, so a watchdog reset never disturbs the taps
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      presc_chain <= '0;
      tap_ten_tick <= 1'b0;
    end else begin
      tap_ten_tick <= 1'b0;
      if (tap_zero_tick) begin
        presc_chain <= presc_chain + 1'b1;
        tap_ten_tick <= (presc_chain[TAP_TEN-1:0] == TAP_TEN_ALL);
      end
    end
  end

  // ==========================================================================
  // watchdog
  assign wdt_set = WDT_SET || cmd_set;
  assign paused = HALT_MODE || STOP_MODE;

  // enable and flag move together; only RSTN takes them down
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wdt_enable <= 1'b0;
      WATCHDOG_FLAG <= 1'b0;
    end else if (wdt_set) begin
      wdt_enable <= 1'b1;
      WATCHDOG_FLAG <= 1'b1;
    end
  end

  // nine-bit up-counter on the tenth tap, frozen in halt and stop
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wdt_count <= '0;
      wdt_overflow <= 1'b0;
    end else begin
      wdt_overflow <= 1'b0;
      if (wdt_set) begin
        wdt_count <= '0;
      end else if (wdt_enable && tap_ten_tick && !paused) begin
        if (wdt_count == TERM) begin
          wdt_count <= '0;
          wdt_overflow <= 1'b1;
        end else begin
          wdt_count <= wdt_count + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // key reset detector
  assign key_mask = KEY_RESET_USE & PIN_IS_INPUT;
  assign key_pins = scan_src ? KEY_SCAN_INPUTS : PORT_C_PINS;
  // an empty mask must not count as all low
  assign all_low = (|key_mask) && ((key_pins & key_mask) == '0);
  // scan source keeps its last verdict until the scan period ends
  assign qualified = scan_src ? (KEY_SCAN_DONE ? all_low : key_low_q) : all_low;

  // one request on each new all-low condition
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      key_low_q <= 1'b0;
      key_req <= 1'b0;
    end else begin
      key_low_q <= qualified;
      key_req <= qualified && !key_low_q;
    end
  end

  // ==========================================================================
  // reset cycle generator
  wkr_reset_hold #(
    .HOLD_CLOCKS(RESET_HOLD_CLOCKS)
  ) u_hold (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .tick(tap_zero_tick),
    .request(wdt_overflow || key_req),
    .hold_n(CHIP_RESET_N)
  );

  // ==========================================================================
  // apb slave
  // one wait state: PREADY rises in the second access cycle
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_en = PSEL && PENABLE && !PREADY && !PWRITE;
  assign cmd_set = wr_en && (PADDR == ADDR_CMD) && PWDATA[CMD_WDT_SET_BIT];
  assign mapped = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) || (PADDR == ADDR_EVENT)
    || (PADDR == ADDR_MASK) || (PADDR == ADDR_CMD);

  // handshake
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
    end
  end

  // read mux; command register reads as zero
  always_comb begin
    next_rdata = '0;
    case (PADDR)
      ADDR_CTRL: begin
        next_rdata[CTRL_SCAN_SRC_BIT] = scan_src;
      end
      ADDR_STATUS: begin
        next_rdata[ST_FLAG_BIT] = WATCHDOG_FLAG;
        next_rdata[ST_EN_BIT] = wdt_enable;
        next_rdata[ST_HOLD_BIT] = !CHIP_RESET_N;
        next_rdata[ST_KEYLOW_BIT] = key_low_q;
        next_rdata[ST_COUNT_LSB +: WDT_WIDTH] = wdt_count;
      end
      ADDR_EVENT: begin
        next_rdata[EV_WIDTH-1:0] = events;
      end
      ADDR_MASK: begin
        next_rdata[EV_WIDTH-1:0] = mask;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // read data latched the cycle before PREADY
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= '0;
    end else if (rd_en) begin
      PRDATA <= next_rdata;
    end
  end

  // control and mask registers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scan_src <= 1'b0;
      mask <= '0;
    end else if (wr_en) begin
      if (PADDR == ADDR_CTRL) begin
        scan_src <= PWDATA[CTRL_SCAN_SRC_BIT];
      end
      if (PADDR == ADDR_MASK) begin
        mask <= PWDATA[EV_WIDTH-1:0];
      end
    end
  end

  // ==========================================================================
  // interrupt
  // write one to clear; an event in the clearing cycle survives
  always_comb begin
    next_events = events;
    if (wr_en && (PADDR == ADDR_EVENT)) begin
      next_events = events & ~PWDATA[EV_WIDTH-1:0];
    end
    next_events[EV_WDT_BIT] = next_events[EV_WDT_BIT] || wdt_overflow;
    next_events[EV_KEY_BIT] = next_events[EV_KEY_BIT] || key_req;
  end

  // sticky events and registered interrupt level
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      events <= '0;
      IRQ <= 1'b0;
    end else begin
      events <= next_events;
      IRQ <= |(next_events & mask);
    end
  end

  // ==========================================================================
  // checks
  ovf_resets_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    wdt_overflow |=> !CHIP_RESET_N)
    else $error("overflow did not start reset");

  ovf_keeps_run_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    wdt_overflow |-> wdt_enable && WATCHDOG_FLAG ##1 wdt_enable && WATCHDOG_FLAG)
    else $error("watchdog reset disturbed the watchdog");

  flag_tracks_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    WATCHDOG_FLAG == wdt_enable)
    else $error("flag and enable disagree");

  set_clears_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    wdt_set |=> wdt_count == '0 && wdt_enable && WATCHDOG_FLAG)
    else $error("set instruction did not clear and enable");

  halt_pause_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (paused && !wdt_set) |=> $stable(wdt_count) && !wdt_overflow)
    else $error("watchdog moved in halt or stop");

  tick_only_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    ($changed(wdt_count) && !$past(wdt_set)) |-> $past(tap_ten_tick))
    else $error("watchdog advanced without tenth tap");

  terminal_ovf_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    wdt_overflow |-> $past(wdt_count) == TERM && wdt_count == '0)
    else $error("overflow at wrong count");

  single_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    wdt_overflow |=> !wdt_overflow)
    else $error("overflow request longer than one cycle");

  key_none_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (key_mask == '0) |=> !key_req)
    else $error("key reset with no pin enabled");

  key_low_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    key_req |-> $past(qualified) && !$past(key_low_q))
    else $error("key request without all-low condition");

  scan_wait_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    ($past(scan_src) && key_req) |-> $past(KEY_SCAN_DONE))
    else $error("scan key reset before scan period ended");

  count_step_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (wdt_enable && tap_ten_tick && !paused && !wdt_set && wdt_count != TERM) |=> wdt_count == $past(wdt_count) + 1'b1)
    else $error("watchdog did not step by one");

  wdt_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !wdt_enable |-> wdt_count == '0)
    else $error("watchdog counted while inactive");

  enable_kept_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    wdt_enable |=> wdt_enable && WATCHDOG_FLAG)
    else $error("watchdog stopped without power-on reset");

  port_fire_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (!scan_src && all_low && !key_low_q) |=> key_req)
    else $error("port c all-low gave no request");

  scan_fire_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (scan_src && KEY_SCAN_DONE && all_low && !key_low_q) |=> key_req)
    else $error("scan all-low gave no request");

  scan_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (scan_src && !KEY_SCAN_DONE) |=> key_low_q == $past(key_low_q))
    else $error("scan verdict changed inside scan period");

  key_resets_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    key_req |=> !CHIP_RESET_N)
    else $error("key request did not start reset");

endmodule : wkr_top

// >>> bench/wkr_cpu_model.sv
/*
  CPU core model: pulses the watchdog set and sleeps when asked.
  Assumes the bench changes service_en and sleep_req right after rising edges.
*/
`timescale 1ns/100ps
module wkr_cpu_model #(
  parameter int PERIOD = 3000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench controls
  input wire logic service_en,
  input wire logic [1:0] sleep_req,
  // cpu outputs
  output logic wdt_set,
  output logic halt_mode,
  output logic stop_mode
);
  // ==========================================================================
  // service and sleep sequencing
  int gap;
  logic asleep;
  // a set every PERIOD + 1 cycles keeps the count well below its terminal value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 0;
      asleep <= 1'b0;
      wdt_set <= 1'b0;
    end else begin
      asleep <= (sleep_req != 2'b00);
      gap <= (wdt_set || !service_en || asleep) ? 0 : gap + 1;
      // one extra set just before sleeping, only while servicing
      wdt_set <= service_en && ((gap == PERIOD - 1) || (sleep_req != 2'b00 && !asleep));
    end
  end
  // sleep levels rise one cycle after the pre-sleep set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
    end else begin
      halt_mode <= asleep && sleep_req[0];
      stop_mode <= asleep && sleep_req[1];
    end
  end
endmodule : wkr_cpu_model

// >>> bench/wkr_top_test.sv
/*
  Bench for the watchdog and key-reset block: APB tasks, cpu model, tests.
  Assumes shortened counts: hold 4 ticks, tick every 2 clocks, interval 8.
*/
`timescale 1ns/100ps
module wkr_top_test;
  import wkr_pkg::*;
  localparam int TAP = 2 * 1024;
  logic SYS_CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, WDT_SET, HALT_MODE, STOP_MODE;
  logic KEY_SCAN_DONE, CHIP_RESET_N, WATCHDOG_FLAG, IRQ, service_en, e;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, d;
  logic [3:0] PORT_C_PINS, KEY_SCAN_INPUTS, PIN_IS_INPUT;
  logic [1:0] sleep_req;
  logic [3:0] pins [4] = '{4'h4, 4'h1, 4'h0, 4'hc};
  logic [3:0] dirs [4] = '{4'hf, 4'hf, 4'h4, 4'h3};
  logic [3:0] hit = 4'b1001;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int lows = 0;
  int n, c;

  // ==========================================================================
  // clock, watchdog of the run, instances
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // a hang counts as a mismatch; lows counts cycles of chip reset after release
  always @(posedge SYS_CLK) begin
    cycles++;
    if (RSTN && CHIP_RESET_N === 1'b0) lows++;
    if (cycles == 90000) begin
      fails++;
      give_verdict();
    end
  end
  wkr_top #(.KEY_RESET_USE(4'hb), .WDT_INTERVAL(8), .RESET_HOLD_CLOCKS(4), .PRESC_CYCLES(2)) u_wkr_top (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .WDT_SET(WDT_SET),
    .HALT_MODE(HALT_MODE), .STOP_MODE(STOP_MODE), .PORT_C_PINS(PORT_C_PINS), .KEY_SCAN_INPUTS(KEY_SCAN_INPUTS),
    .PIN_IS_INPUT(PIN_IS_INPUT), .KEY_SCAN_DONE(KEY_SCAN_DONE), .CHIP_RESET_N(CHIP_RESET_N),
    .WATCHDOG_FLAG(WATCHDOG_FLAG), .IRQ(IRQ));
  wkr_cpu_model u_wkr_cpu_model (.clk(SYS_CLK), .rst_n(RSTN), .service_en(service_en), .sleep_req(sleep_req),
    .wdt_set(WDT_SET), .halt_mode(HALT_MODE), .stop_mode(STOP_MODE));

  // ==========================================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge SYS_CLK);
  endtask : cyc
  // one transfer, entered and left just after a rising edge; idle cycle after it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    // only the run timeout ends this wait
    while (PREADY !== 1'b1) begin
      @(posedge SYS_CLK);
    end
    d = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : apb
  // inputs changed at the last edge; chip reset must fall two cycles later or never
  task automatic key_check(input string what, input logic exp);
    @(posedge SYS_CLK);
    KEY_SCAN_DONE <= 1'b0;
    chk(what, 1, CHIP_RESET_N);
    @(posedge SYS_CLK);
    chk(what, 1, CHIP_RESET_N);
    @(posedge SYS_CLK);
    chk(what, !exp, CHIP_RESET_N);
    PORT_C_PINS <= 4'hf;
    KEY_SCAN_INPUTS <= 4'hf;
    cyc(30);
  endtask : key_check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // tests
  initial begin
    RSTN = 1'b0;
    {PSEL, PENABLE, PWRITE, KEY_SCAN_DONE, service_en} = 5'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    {PORT_C_PINS, KEY_SCAN_INPUTS, PIN_IS_INPUT} = 12'hfff;
    sleep_req = 2'h0;
    cyc(5);
    RSTN <= 1'b1;
    chk("flag at reset", 0, WATCHDOG_FLAG);
    apb(1'b0, ADDR_STATUS, 0);
    chk("enable at reset", 0, d[ST_EN_BIT]);
    chk("chip reset held", 0, CHIP_RESET_N);
    n = 0;
    while (CHIP_RESET_N !== 1'b1 && n < 40) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("hold released", 1, CHIP_RESET_N);
    apb(1'b0, 8'h40, 0);
    chk("unmapped error", 1, e);
    apb(1'b1, ADDR_MASK, 32'h3);
    apb(1'b0, ADDR_MASK, 0);
    chk("mask", 32'h3, d);
    $display("test reset done");
    lows = 0;
    service_en <= 1'b1;
    cyc(25000);
    chk("flag set", 1, WATCHDOG_FLAG);
    chk("serviced, no reset", 0, lows);
    service_en <= 1'b0;
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b0, ADDR_STATUS, 0);
    chk("count cleared", 1, d[24:16] <= 1);
    cyc(4500);
    apb(1'b0, ADDR_STATUS, 0);
    chk("count rate", 1, d[24:16] >= 2 && d[24:16] <= 3);
    sleep_req <= 2'b01;
    // take the reference count once halt is in force, so a late tick cannot slip in
    cyc(4);
    apb(1'b0, ADDR_STATUS, 0);
    c = d[24:16];
    cyc(6000);
    apb(1'b0, ADDR_STATUS, 0);
    chk("held in halt", c, d[24:16]);
    sleep_req <= 2'b10;
    cyc(6000);
    apb(1'b0, ADDR_STATUS, 0);
    chk("held in stop", c, d[24:16]);
    sleep_req <= 2'b00;
    cyc(2100);
    apb(1'b0, ADDR_STATUS, 0);
    chk("resumed", 1, d[24:16] > c && d[24:16] <= c + 2);
    $display("test sleep done");
    apb(1'b1, ADDR_CMD, 32'h1);
    n = 0;
    while (CHIP_RESET_N !== 1'b0 && n < 20000) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("overflow time", 1, n >= 7 * TAP && n <= 8 * TAP + 4);
    n = 0;
    while (CHIP_RESET_N === 1'b0 && n < 40) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("hold length", 1, n >= 7 && n <= 10);
    chk("flag kept", 1, WATCHDOG_FLAG);
    chk("irq raised", 1, IRQ);
    apb(1'b0, ADDR_EVENT, 0);
    chk("overflow event", 32'h1, d);
    apb(1'b1, ADDR_EVENT, 32'h1);
    chk("irq cleared", 0, IRQ);
    cyc(4200);
    apb(1'b0, ADDR_STATUS, 0);
    chk("still counting", 1, d[ST_EN_BIT] && d[24:16] >= 1);
    service_en <= 1'b1;
    $display("test overflow done");
    for (int i = 0; i < 4; i++) begin
      PORT_C_PINS <= pins[i];
      PIN_IS_INPUT <= dirs[i];
      key_check("key reset port c", hit[i]);
    end
    apb(1'b1, ADDR_CTRL, 32'h1);
    PIN_IS_INPUT <= 4'hf;
    KEY_SCAN_INPUTS <= 4'h0;
    cyc(10);
    chk("scan waits", 1, CHIP_RESET_N);
    KEY_SCAN_DONE <= 1'b1;
    key_check("key reset scan", 1'b1);
    apb(1'b0, ADDR_EVENT, 0);
    chk("key event", 32'h2, d);
    $display("test keys done");
    give_verdict();
  end
endmodule : wkr_top_test
